//--- rtl/sfm_slave.sv
// Serial nonvolatile byte memory slave: command decode, status, array access
//
// What this block does
// (RULE1) Slave works in clock modes 0 and 3
// (RULE2) Chip select high: standby, output floats
// (RULE3) Sample on rising edge, shift on falling
// (RULE4) Pause low floats output, ignores clock, data
// (RULE5) Decode latch set/clear and status opcodes
// (RULE6) Decode read, write, quick read; ident and sleep fall to the no-data default
// (RULE7) Partial opcode before deselect does nothing
// (RULE8) Master sends only defined opcodes
// (RULE9) Set command sets the write latch
// (RULE10) Latch clear blocks all writes
// (RULE11) Latch clears on command or write end
// (RULE12) Status read repeats status byte continuously
// (RULE13) Status write stores bits seven to two
// (RULE14) Lock bit, spare bits, two size bits
// (RULE15) Master holds protect pin during status write
// (RULE16) Read takes 24-bit address, then streams bytes
// (RULE17) Read increments address and wraps to zero
// (RULE18) Write commits each byte when complete
// (RULE19) Write increments address and wraps to zero
// (RULE20) Quick read adds eight dummy bits
// (RULE21) Size bits select protected upper block
// (RULE22) Status lock blocks only with pin low
// (RULE23) Pause suspends; deselect during pause aborts
// (RULE24) Seventeen address bits index the array
`timescale 1ns/1ps
module sfm_slave
    import sfm_pkg::*;
#(
    parameter int ADDR_W = sfm_pkg::MEM_ADDR_W,
    parameter int DEPTH = sfm_pkg::MEM_DEPTH
) (
    input wire logic mclk,  // System clock, 100 MHz
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic csN,   // Chip select pin, active low
    input wire logic sck,   // Serial clock pin
    input wire logic si,    // Serial data in pin
    input wire logic holdN, // Pause pin, active low
    input wire logic wpN,   // Write protect pin, active low
    output logic soOut,     // Serial data out level
    output logic soOe       // Serial data out enable, high drives
);
    import sfm_pkg::*;

    // ****************************************
    // Pin synchronisation and edge finding
    // ****************************************
    logic [PIN_COUNT-1:0] pinRaw;
    logic [PIN_COUNT-1:0] pinLvl;
    logic csLvl;
    logic sckLvl;
    logic siLvl;
    logic holdLvl;
    logic wpLvl;
    logic sckPrev;
    logic csPrev;
    logic active;
    logic sckRise;
    logic sckFall;
    logic csRise;

    assign pinRaw = {csN, sck, si, holdN, wpN};

    generate
        for (genvar i = 0; i < PIN_COUNT; i++) begin : gSync
            sfm_pin_sync #(
                .RESET_VAL(PIN_RESET[i])
            ) uSync (
                .mclk(mclk),
                .rst_n(rst_n),
                .pinIn(pinRaw[i]),
                .level(pinLvl[i])
            );
        end
    endgenerate

    assign csLvl = pinLvl[PIN_CS];
    assign sckLvl = pinLvl[PIN_SCK];
    assign siLvl = pinLvl[PIN_SI];
    assign holdLvl = pinLvl[PIN_HOLD];
    assign wpLvl = pinLvl[PIN_WP];

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sckPrev <= 1'b0;
            csPrev <= 1'b1;
        end else begin
            sckPrev <= sckLvl;
            csPrev <= csLvl;
        end
    end

    // Edges are only seen while selected and not paused
    assign active = !csLvl && holdLvl; // RULE2 RULE4
    // Mode 0 and mode 3 differ only in idle level; both use these edges
    assign sckRise = active && sckLvl && !sckPrev; // RULE1 RULE3
    assign sckFall = active && !sckLvl && sckPrev; // RULE1 RULE3
    assign csRise = csLvl && !csPrev;

    // ****************************************
    // Storage
    // ****************************************
    sfm_state_e state;
    logic [4:0] bitCnt;
    logic [22:0] shiftIn;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] addrNext;
    logic [7:0] outShift;
    logic isQuick;
    logic isWrite;
    logic writeSeen;
    logic writeLatchFlag;
    logic [5:0] statusNv;
    logic [7:0] statusByte;
    logic [7:0] mem [0:DEPTH-1];

    logic [7:0] inByte;
    logic [ADDR_W-1:0] addrIn;
    logic [4:0] lastBit;
    logic atLast;
    logic opDone;
    logic memWrEn;
    logic statWrEn;

    assign statusByte = {statusNv, writeLatchFlag, 1'b0}; // RULE13 RULE14
    assign inByte = {shiftIn[6:0], siLvl};
    // Upper address bits are shifted in but never used
    assign addrIn = {shiftIn[ADDR_W-2:0], siLvl}; // RULE16 RULE24
    assign addrNext = addr + 1'b1; // RULE17 RULE19 RULE24

    // ****************************************
    // Decode helpers
    // ****************************************
    function automatic logic [4:0] frameLen(input sfm_state_e st);
        case (st)
            ST_OPCODE: frameLen = OPCODE_BITS;
            ST_ADDR: frameLen = ADDR_BITS;
            ST_DUMMY: frameLen = DUMMY_BITS;
            default: frameLen = DATA_BITS;
        endcase
    endfunction : frameLen

    function automatic logic addrProtected(input logic [1:0] size,
                                           input logic [ADDR_W-1:0] a);
        case (size)
            PROT_NONE: addrProtected = 1'b0;
            PROT_QUARTER: addrProtected = (a[ADDR_W-1:ADDR_W-2] == 2'h3);
            PROT_HALF: addrProtected = a[ADDR_W-1];
            default: addrProtected = 1'b1;
        endcase
    endfunction : addrProtected

    assign lastBit = frameLen(state) - 5'h01;
    assign atLast = sckRise && (bitCnt == lastBit);
    assign opDone = atLast && (state == ST_OPCODE);

    // Writes need the latch and an unprotected target
    assign memWrEn = atLast && (state == ST_WDATA) && writeLatchFlag
        && !addrProtected(statusNv[STAT_SIZE_HI_BIT-STAT_NV_LSB:STAT_SIZE_LO_BIT-STAT_NV_LSB],
                          addr); // RULE10 RULE18 RULE21 RULE22
    assign statWrEn = atLast && (state == ST_SWRITE) && writeLatchFlag
        && !(statusNv[STAT_LOCK_BIT-STAT_NV_LSB] && !wpLvl); // RULE10 RULE22

    // ****************************************
    // Command sequencer
    // ****************************************
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state <= ST_OPCODE;
            bitCnt <= 5'h00;
            shiftIn <= 23'h000000;
            addr <= '0;
            outShift <= 8'h00;
            isQuick <= 1'b0;
            isWrite <= 1'b0;
        end else if (csLvl) begin
            // Deselect drops any partial or running command
            state <= ST_OPCODE; // RULE2 RULE7 RULE23
            bitCnt <= 5'h00;
        end else if (sckRise) begin
            shiftIn <= {shiftIn[21:0], siLvl}; // RULE3
            bitCnt <= atLast ? 5'h00 : bitCnt + 5'h01;
            if (atLast) begin
                case (state)
                    ST_OPCODE: begin
                        case (inByte) // RULE5 RULE6
                            OP_STATUS_READ: begin
                                state <= ST_SREAD;
                                outShift <= statusByte; // RULE12
                            end
                            OP_STATUS_WRITE: state <= ST_SWRITE;
                            OP_MEM_READ: begin
                                state <= ST_ADDR;
                                isQuick <= 1'b0;
                                isWrite <= 1'b0;
                            end
                            OP_QUICK_READ: begin
                                state <= ST_ADDR;
                                isQuick <= 1'b1; // RULE20
                                isWrite <= 1'b0;
                            end
                            OP_MEM_WRITE: begin
                                state <= ST_ADDR;
                                isQuick <= 1'b0;
                                isWrite <= 1'b1;
                            end
                            // Latch commands, ident and sleep need no data phase here
                            default: state <= ST_DUMMY;
                        endcase
                        if (inByte != OP_MEM_READ && inByte != OP_QUICK_READ
                            && inByte != OP_MEM_WRITE && inByte != OP_STATUS_READ
                            && inByte != OP_STATUS_WRITE) begin
                            isWrite <= 1'b0;
                            isQuick <= 1'b1;
                        end
                    end
                    ST_ADDR: begin
                        addr <= addrIn; // RULE16 RULE18
                        if (isWrite) begin
                            state <= ST_WDATA;
                        end else if (isQuick) begin
                            state <= ST_DUMMY; // RULE20
                        end else begin
                            state <= ST_RDATA;
                            outShift <= mem[addrIn]; // RULE16
                        end
                    end
                    ST_DUMMY: begin
                        // A command with no data phase also moves on to ST_RDATA after eight bits; quiet keeps the output floating
                        if (!isWrite && isQuick && shiftIn[22]) begin
                            state <= ST_DUMMY;
                        end
                        state <= ST_RDATA;
                        outShift <= mem[addr]; // RULE20
                    end
                    ST_RDATA: begin
                        addr <= addrNext; // RULE17
                        outShift <= mem[addrNext]; // RULE17
                    end
                    ST_WDATA: addr <= addrNext; // RULE19
                    ST_SREAD: outShift <= statusByte; // RULE12
                    ST_SWRITE: state <= ST_SWRITE;
                    default: state <= ST_OPCODE;
                endcase
            end
        end else if (sckFall && (state == ST_RDATA || state == ST_SREAD)) begin
            outShift <= {outShift[6:0], 1'b0}; // RULE3
        end
    end

    // ****************************************
    // Command that has no data phase
    // ****************************************
    logic quiet;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            quiet <= 1'b0;
        end else if (csLvl) begin
            quiet <= 1'b0;
        end else if (opDone) begin
            // Latch, ident, sleep and unknown codes keep the output floating
            quiet <= !(inByte == OP_MEM_READ || inByte == OP_QUICK_READ
                       || inByte == OP_MEM_WRITE || inByte == OP_STATUS_READ
                       || inByte == OP_STATUS_WRITE); // RULE8
        end
    end

    // ****************************************
    // Serial output
    // ****************************************
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            soOut <= 1'b0;
            soOe <= 1'b0;
        end else begin
            soOe <= active && !quiet
                && (state == ST_RDATA || state == ST_SREAD); // RULE2 RULE4
            if (sckFall && !quiet && (state == ST_RDATA || state == ST_SREAD)) begin
                soOut <= outShift[7]; // RULE3 RULE12 RULE16
            end
        end
    end

    // ****************************************
    // Write latch
    // ****************************************
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            writeLatchFlag <= 1'b0; // RULE11
            writeSeen <= 1'b0;
        end else begin
            if (csRise) begin
                writeSeen <= 1'b0;
            end else if (opDone && (inByte == OP_MEM_WRITE || inByte == OP_STATUS_WRITE)) begin
                writeSeen <= 1'b1;
            end
            // A pause abort before recognition leaves the latch untouched
            if (csRise && writeSeen) begin
                writeLatchFlag <= 1'b0; // RULE11 RULE23
            end else if (opDone && inByte == OP_SET_WRITE_LATCH) begin
                writeLatchFlag <= 1'b1; // RULE9
            end else if (opDone && inByte == OP_CLEAR_WRITE_LATCH) begin
                writeLatchFlag <= 1'b0; // RULE10 RULE11
            end
        end
    end

    // ****************************************
    // Status bits and array
    // ****************************************
    // Nonvolatile bits are cleared by reset to give simulation a known start
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            statusNv <= STAT_NV_RESET;
        end else if (statWrEn) begin
            statusNv <= inByte[7:STAT_NV_LSB]; // RULE13 RULE14 RULE15
        end
    end

    always_ff @(posedge mclk) begin
        if (memWrEn) begin
            mem[addr] <= inByte; // RULE18 RULE19
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    chk_desel_float: assert property (@(posedge mclk) disable iff (!rst_n) // RULE2
        csLvl |=> !soOe)
        else $error("output driven while deselected");

    chk_pause_float: assert property (@(posedge mclk) disable iff (!rst_n) // RULE4
        !holdLvl |=> !soOe)
        else $error("output driven during pause");

    chk_partial_drop: assert property (@(posedge mclk) disable iff (!rst_n) // RULE7
        csLvl |=> (state == ST_OPCODE) && (bitCnt == 5'h00))
        else $error("partial command survived deselect");

    chk_latch_set: assert property (@(posedge mclk) disable iff (!rst_n) // RULE9
        opDone && inByte == OP_SET_WRITE_LATCH |=> writeLatchFlag && statusByte[STAT_LATCH_BIT])
        else $error("latch not set");

    chk_latch_clear: assert property (@(posedge mclk) disable iff (!rst_n) // RULE10
        opDone && inByte == OP_CLEAR_WRITE_LATCH |=> !writeLatchFlag)
        else $error("latch not cleared");

    chk_latch_end_write: assert property (@(posedge mclk) disable iff (!rst_n) // RULE11
        csRise && (state == ST_WDATA || state == ST_SWRITE) |=> !writeLatchFlag)
        else $error("latch kept after write");

    chk_status_reload: assert property (@(posedge mclk) disable iff (!rst_n) // RULE12
        atLast && state == ST_SREAD |=> outShift == $past(statusByte))
        else $error("status byte not reloaded");

    chk_status_store: assert property (@(posedge mclk) disable iff (!rst_n) // RULE13
        statWrEn |=> statusNv == $past(inByte[7:2]) && statusByte[0] == 1'b0)
        else $error("status write not stored");

    chk_read_wrap: assert property (@(posedge mclk) disable iff (!rst_n) // RULE17
        atLast && state == ST_RDATA && (&addr) |=> addr == '0)
        else $error("read address did not wrap");

    chk_protect_gate: assert property (@(posedge mclk) disable iff (!rst_n) // RULE21
        memWrEn |-> writeLatchFlag && !(statusNv[1:0] == PROT_ALL)
            && !(statusNv[1:0] == PROT_HALF && addr[ADDR_W-1]))
        else $error("write into protected block");

    chk_lock_gate: assert property (@(posedge mclk) disable iff (!rst_n) // RULE22
        statWrEn |-> writeLatchFlag && (wpLvl || !statusNv[5]))
        else $error("status written while locked");

    chk_quick_dummy: assert property (@(posedge mclk) disable iff (!rst_n) // RULE20
        atLast && state == ST_ADDR && isQuick && !isWrite |=> state == ST_DUMMY)
        else $error("quick read skipped dummy byte");
endmodule : sfm_slave

//--- rtl/sfm_pkg.sv
// Shared constants and types for the serial nonvolatile byte memory slave
package sfm_pkg;

    // ****************************************
    // Array geometry
    // ****************************************
    localparam int MEM_ADDR_W = 17;
    localparam int MEM_DEPTH = 131072;

    // ****************************************
    // Serial frame lengths in clock edges
    // ****************************************
    localparam logic [4:0] OPCODE_BITS = 5'h08;
    localparam logic [4:0] ADDR_BITS = 5'h18;
    localparam logic [4:0] DUMMY_BITS = 5'h08;
    localparam logic [4:0] DATA_BITS = 5'h08;

    // ****************************************
    // Opcodes
    // ****************************************
    localparam logic [7:0] OP_SET_WRITE_LATCH = 8'h06;
    localparam logic [7:0] OP_CLEAR_WRITE_LATCH = 8'h04;
    localparam logic [7:0] OP_STATUS_READ = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_MEM_READ = 8'h03;
    localparam logic [7:0] OP_MEM_WRITE = 8'h02;
    localparam logic [7:0] OP_IDENT_READ = 8'h9f;
    localparam logic [7:0] OP_QUICK_READ = 8'h0b;
    localparam logic [7:0] OP_SLEEP = 8'hb9;

    // ****************************************
    // Status byte layout
    // ****************************************
    localparam int STAT_LOCK_BIT = 7;
    localparam int STAT_SIZE_HI_BIT = 3;
    localparam int STAT_SIZE_LO_BIT = 2;
    localparam int STAT_LATCH_BIT = 1;
    localparam int STAT_NV_LSB = 2;
    localparam logic [5:0] STAT_NV_RESET = 6'h00;

    // ****************************************
    // Block protect sizes
    // ****************************************
    localparam logic [1:0] PROT_NONE = 2'h0;
    localparam logic [1:0] PROT_QUARTER = 2'h1;
    localparam logic [1:0] PROT_HALF = 2'h2;
    localparam logic [1:0] PROT_ALL = 2'h3;

    // ****************************************
    // Pin vector positions and reset levels
    // ****************************************
    localparam int PIN_COUNT = 5;
    localparam int PIN_CS = 4;
    localparam int PIN_SCK = 3;
    localparam int PIN_SI = 2;
    localparam int PIN_HOLD = 1;
    localparam int PIN_WP = 0;
    localparam logic [4:0] PIN_RESET = 5'h13;

    typedef enum logic [6:0] {
        ST_OPCODE = 7'h01,
        ST_ADDR = 7'h02,
        ST_DUMMY = 7'h04,
        ST_RDATA = 7'h08,
        ST_WDATA = 7'h10,
        ST_SWRITE = 7'h20,
        ST_SREAD = 7'h40
    } sfm_state_e;

endpackage : sfm_pkg

//--- rtl/sfm_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module sfm_pin_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic mclk,  // System clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic pinIn, // Asynchronous pin level
    output logic level      // Filtered level in the mclk domain
);
    logic stage1;
    logic stage2;
    logic stage3;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            stage1 <= RESET_VAL;
            stage2 <= RESET_VAL;
            stage3 <= RESET_VAL;
            level <= RESET_VAL;
        end else begin
            stage1 <= pinIn;
            stage2 <= stage1;
            stage3 <= stage2;
            // A change is taken only once two later stages agree
            if (stage2 == stage3) begin
                level <= stage3;
            end
        end
    end
endmodule : sfm_pin_sync

//--- tb/sfm_spi_master.sv
// Serial master model driving the slave pins in clock mode 0 or 3
`timescale 1ns/1ps
module sfm_spi_master (
    input wire logic mclk,  // Bench clock, used only to align pin changes
    input wire logic so,    // Resolved serial out wire
    input wire logic soOe,  // Slave output enable
    output logic csN,       // Chip select, active low
    output logic sck,       // Serial clock
    output logic si,        // Serial data to slave
    output logic holdN,     // Pause, active low
    output logic wpN        // Write protect, active low
);
    logic cpol;
    logic anyOe;
    logic pausedOe;
    logic [63:0] rx;
    event rxEvt;

    initial begin
        cpol = 1'b0;
        csN = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        holdN = 1'b1;
        wpN = 1'b1;
    end

    // ****************************************
    // One framed transfer, MSB first
    // ****************************************
    // Output settles long after each fall, so it is sampled just before the next fall
    task automatic frame(input int n, input logic [63:0] tx, input int pauseAt,
                         input bit emit);
        int i;
        @(posedge mclk);
        #1;
        // Cleared only now so the checker still sees the previous frame
        rx = '0;
        anyOe = 1'b0;
        sck = cpol;
        #100;
        csN = 1'b0;
        #100;
        for (i = 0; i < n; i++) begin
            if (i == pauseAt) begin
                holdN = 1'b0;
                #100;
                // Garbage edges while paused; chip select stays low throughout
                repeat (4) begin
                    sck = ~sck;
                    si = ~si;
                    #80;
                end
                pausedOe = soOe;
                holdN = 1'b1;
                #100;
            end
            rx = {rx[62:0], so};
            anyOe = anyOe | soOe;
            sck = 1'b0;
            si = tx[n-1-i];
            #40;
            sck = 1'b1;
            #40;
        end
        rx = {rx[62:0], so};
        sck = cpol;
        #40;
        csN = 1'b1;
        if (emit) begin
            ->rxEvt;
        end
    endtask : frame

endmodule : sfm_spi_master

//--- tb/tb_top.sv
// Self-checking bench for the serial memory slave
`timescale 1ns/1ps
module tb_top;
    import sfm_pkg::*;

    logic mclk = 1'b0;
    logic rst_n, csN, sck, si, holdN, wpN, soOut, soOe, so, wl;
    logic [7:0] stat;
    logic [7:0] mem[int];
    logic [63:0] expQ[$];
    logic [63:0] mskQ[$];
    logic [16:0] addrs[4] = '{17'h0ffff, 17'h10000, 17'h17fff, 17'h18000};
    int n_fail;
    int total_checks;

    sfm_slave dut_u (.mclk(mclk), .rst_n(rst_n), .csN(csN), .sck(sck), .si(si),
        .holdN(holdN), .wpN(wpN), .soOut(soOut), .soOe(soOe));
    sfm_spi_master m_u (.mclk(mclk), .so(so), .soOe(soOe), .csN(csN), .sck(sck),
        .si(si), .holdN(holdN), .wpN(wpN));

    // A released line shows the inverse of the last driven bit
    assign so = soOe ? soOut : ~soOut;

    always #5 mclk = ~mclk;

    // ****************************************
    // Checking
    // ****************************************
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    always @(m_u.rxEvt) begin
        check(m_u.rx & mskQ[0], expQ.pop_front());
        void'(mskQ.pop_front());
    end

    task automatic stop_test();
        if (n_fail == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test

    // ****************************************
    // Commands
    // ****************************************
    task automatic rd(input int n, input logic [63:0] tx, input logic [63:0] e,
                      input int nd, input int p = -1);
        expQ.push_back(e);
        mskQ.push_back((64'h1 << nd) - 64'h1);
        m_u.cpol = 1'($urandom);
        m_u.frame(n, tx, p, 1'b1);
    endtask : rd

    task automatic op(input logic [7:0] code);
        m_u.cpol = 1'($urandom);
        m_u.frame(8, 64'(code), -1, 1'b0);
    endtask : op

    task automatic setl();
        op(OP_SET_WRITE_LATCH);
        wl = 1'b1;
    endtask : setl

    task automatic sread();
        logic [7:0] s;
        s = stat | {6'h00, wl, 1'b0};
        rd(24, {40'h0, OP_STATUS_READ, 16'($urandom)}, {48'h0, s, s}, 16);
    endtask : sread

    task automatic swr(input logic [7:0] v);
        op_frame: m_u.frame(16, {48'h0, OP_STATUS_WRITE, v}, -1, 1'b0);
        if (wl && !(stat[7] && !wpN)) begin
            stat = v & 8'hfc;
        end
        wl = 1'b0;
    endtask : swr

    function automatic bit prot(input logic [16:0] a);
        case (stat[3:2])
            PROT_NONE: return 1'b0;
            PROT_QUARTER: return a >= 17'h18000;
            PROT_HALF: return a >= 17'h10000;
            default: return 1'b1;
        endcase
    endfunction : prot

    task automatic mwr(input logic [16:0] a, input int nb);
        logic [63:0] tx;
        logic [7:0] d;
        tx = {32'h0, OP_MEM_WRITE, 7'($urandom), a};
        for (int k = 0; k < nb; k++) begin
            d = 8'($urandom);
            tx = {tx[55:0], d};
            if (wl && !prot(a + 17'(k))) begin
                mem[int'(a + 17'(k))] = d;
            end
        end
        m_u.frame(32 + 8 * nb, tx, -1, 1'b0);
        wl = 1'b0;
    endtask : mwr

    task automatic mread(input logic [7:0] code, input logic [16:0] a, input int nb,
                         input int p = -1);
        logic [63:0] tx;
        logic [63:0] e;
        int n;
        tx = {32'h0, code, 7'($urandom), a};
        n = 32;
        e = '0;
        if (code == OP_QUICK_READ) begin
            tx = {tx[55:0], 8'($urandom)};
            n = 40;
        end
        for (int k = 0; k < nb; k++) begin
            tx = {tx[55:0], 8'($urandom)};
            e = {e[55:0], mem[int'(a + 17'(k))]};
        end
        rd(n + 8 * nb, tx, e, 8 * nb, p);
    endtask : mread

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rst_n = 1'b0;
        stat = 8'h00;
        wl = 1'b0;
        n_fail = 0;
        total_checks = 0;
        void'($urandom(32'hc5baef87));
        repeat (5) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        repeat (6) @(posedge mclk);
        #1;
        check(soOe, 64'h0);
        sread();
        setl();
        sread();
        m_u.frame(4, 64'h0, -1, 1'b0);
        sread();
        op(OP_CLEAR_WRITE_LATCH);
        wl = 1'b0;
        sread();
        setl();
        mwr(17'h1fffe, 3);
        sread();
        mwr(17'h1fffe, 3);
        mread(OP_MEM_READ, 17'h1fffe, 3);
        mread(OP_QUICK_READ, 17'h1ffff, 2, 45);
        check(m_u.pausedOe, 64'h0);
        for (int bp = 0; bp < 4; bp++) begin
            setl();
            swr({1'b1, 3'($urandom), 2'(bp), 2'b11});
            sread();
            foreach (addrs[i]) begin
                setl();
                mwr(addrs[i], 1);
                mread(OP_MEM_READ, addrs[i], 1);
            end
        end
        m_u.wpN = 1'b0;
        setl();
        swr(8'h00);
        sread();
        m_u.wpN = 1'b1;
        setl();
        swr(8'h00);
        sread();
        m_u.frame(40, {24'h0, OP_IDENT_READ, 32'h0}, -1, 1'b0);
        check(m_u.anyOe, 64'h0);
        op(OP_SLEEP);
        sread();
        #100;
        stop_test();
    end

    initial begin
        #400000;
        n_fail++;
        stop_test();
    end

endmodule : tb_top
